// File: hdl/lje_alu.sv
// Logical product, selective and load/add datapath
`timescale 1ns/100ps
module lje_alu (
	// Operation
	input wire lje_pkg::lje_op_t opc,
	// Operands
	input wire logic [lje_pkg::W-1:0] a,
	input wire logic [lje_pkg::W-1:0] q,
	input wire logic [lje_pkg::W-1:0] x,
	input wire logic [lje_pkg::W-1:0] y,
	// Results
	output logic [lje_pkg::W-1:0] a_nxt,
	output logic [lje_pkg::W-1:0] x_nxt,
	output logic [lje_pkg::W-1:0] probe
);
	import lje_pkg::*;

	logic [W-1:0] yq;

	assign yq = y & q;

	always_comb begin
		a_nxt = a;
		x_nxt = x;
		probe = a;
		case (opc)
			OP_RADD1: a_nxt = y + 30'h1;
			OP_RSUB1: a_nxt = y - 30'h1;
			OP_ELP, OP_RLP: begin
				x_nxt = yq;
				a_nxt = yq;
			end
			OP_ALP, OP_RALP: begin
				x_nxt = yq;
				a_nxt = a + yq;
			end
			OP_SLP, OP_RSLP: begin
				x_nxt = yq;
				a_nxt = a - yq;
			end
			OP_MCMP: begin
				x_nxt = yq;
				probe = a - yq;
				a_nxt = probe + yq;
			end
			OP_STLP: x_nxt = a & q;
			OP_SSET, OP_RSSET: a_nxt = a | y;
			OP_SCPL, OP_RSCPL: a_nxt = a ^ y;
			OP_SCLR, OP_RSCLR: a_nxt = a & ~y;
			OP_SUBST, OP_RSUBST: begin
				x_nxt = yq;
				a_nxt = (a & ~q) | yq;
			end
			default: a_nxt = a;
		endcase
	end
endmodule // lje_alu

// File: hdl/lje_cond.sv
// Jump, skip and halt condition evaluation
`timescale 1ns/100ps
module lje_cond (
	// Operation
	input wire lje_pkg::lje_op_t opc,
	input wire lje_pkg::lje_sel_t j,
	input wire lje_pkg::lje_sel_t k,
	// Tested state
	input wire logic [lje_pkg::W-1:0] a,
	input wire logic [lje_pkg::W-1:0] q,
	input wire logic [lje_pkg::W-1:0] probe,
	input wire logic [lje_pkg::NCH-1:0] keys,
	input wire logic [lje_pkg::NCH-1:0] hold,
	// Decisions
	output logic take,
	output logic skip,
	output logic stop
);
	import lje_pkg::*;

	function automatic logic arith(input lje_sel_t s, input logic [W-1:0] av,
		input logic [W-1:0] qv);
		logic r;
		r = 1'b0;
		case (s)
			3'h0: r = 1'b0;
			3'h1: r = 1'b1;
			3'h2: r = ~qv[W-1];
			3'h3: r = qv[W-1];
			3'h4: r = (av == RST_WORD);
			3'h5: r = (av != RST_WORD);
			3'h6: r = ~av[W-1];
			3'h7: r = av[W-1];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	always_comb begin
		take = 1'b0;
		skip = 1'b0;
		stop = 1'b0;
		case (opc)
			OP_AJ, OP_ARJ: take = arith(j, a, q);
			OP_MJ: begin
				take = (j == 3'h0) || j[2] || keys[j];
				stop = (j == J_HALT) || (j[2] && keys[j]);
			end
			OP_IJ: take = hold[j];
			OP_OJ: take = ~hold[j];
			OP_MCMP: skip = arith(j, probe, q);
			// selector ignored for k 0 or 4
			OP_STLP: skip = (k != K_NOJ0) && (k != K_NOJ4) && arith(j, a, q);
			default: take = 1'b0;
		endcase
	end
endmodule // lje_cond

// File: hdl/lje_exec.sv
// Execution unit for logical, selective and jump instructions with Avalon-MM registers
// What this block does
// - 36/37 load operand plus/minus one, store
// - 40 load AND of operand and Q
// - 41/42 add or subtract the AND product
// - 43 masked compare skips, accumulator unchanged, X loads the AND product
// - 44-46 product ops then store accumulator
// - 47 store A AND Q, skip on selector unless k is 0 or 4
// - 50-52 selective set, complement, clear accumulator
// - 53 substitute operand bits under Q mask
// - 54-57 selective ops then store accumulator
// - 60 jump selected by arithmetic condition
// - taken jump loads low 15 operand bits
// - untaken jump continues at next address
// - 61 jump on selected console key 1-3, selector 0 always jumps
// - 61 selectors 4-7 jump, halt on 4 or when the selected key is set
// - 62 jump when channel holds data
// - 63 jump when channel is empty
// - 64 return jump on arithmetic condition
// - return jump saves address, stores low half
// - words 30 bits, addresses zero-extended
`timescale 1ns/100ps
module lje_exec (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire lje_pkg::lje_addr_t avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Console keys and channel holding flags
	input wire logic [lje_pkg::NCH-1:0] console_keys,
	input wire logic [lje_pkg::NCH-1:0] chan_hold,
	// Core storage write port
	output logic mem_wr_req,
	output logic [lje_pkg::AW-1:0] mem_wr_addr,
	output logic [lje_pkg::W-1:0] mem_wr_data,
	output lje_pkg::lje_sel_t mem_wr_mode,
	output logic mem_wr_low_half,
	input wire logic mem_wr_ack,
	// Status
	output logic busy,
	output logic halted
);
	import lje_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_EXEC = 3'b010,
		S_STORE = 3'b100
	} lje_state_t;

	lje_state_t state_r, state_nxt;
	logic resp_r, wr_go, rd_cap;
	logic [31:0] rd_mux, wr_word, readdata_r;
	logic [W-1:0] a_r, q_r, x_r, y_r, wdata_r, a_nxt, x_nxt, probe, p_wide;
	logic [AW-1:0] p_r, oaddr_r, waddr_r;
	logic [CMD_BITS-1:0] cmd_r;
	logic halt_r, skip_r, jump_r, rj_r, req_r, wlow_r;
	logic [NCH-1:0] keys_s1_r, keys_s2_r, hold_s1_r, hold_s2_r;
	lje_sel_t wmode_r, sel_j, sel_k;
	lje_op_t opc;
	logic take, skip, stop, is_store, is_jump, ret_jump, exec, idle, clr_halt;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Avalon handshake: one wait cycle per access
	assign avs_waitrequest = (avs_read || avs_write) && !resp_r;
	assign wr_go = avs_write && resp_r;
	assign rd_cap = avs_read && !resp_r;
	assign avs_readdata = readdata_r;
	assign wr_word = merge(rd_mux, avs_writedata, avs_byteenable);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resp_r <= 1'b0;
		end else begin
			resp_r <= (avs_read || avs_write) && !resp_r;
		end
	end

	// Pin synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			keys_s1_r <= '0;
			keys_s2_r <= '0;
			hold_s1_r <= '0;
			hold_s2_r <= '0;
		end else begin
			keys_s1_r <= console_keys;
			keys_s2_r <= keys_s1_r;
			hold_s1_r <= chan_hold;
			hold_s2_r <= hold_s1_r;
		end
	end

	// Instruction decode
	assign opc = cmd_r[CMD_OP_LSB +: 6];
	assign sel_j = cmd_r[CMD_J_LSB +: 3];
	assign sel_k = cmd_r[CMD_K_LSB +: 3];
	assign idle = (state_r == S_IDLE);
	assign exec = (state_r == S_EXEC);
	assign busy = !idle;
	assign halted = halt_r;
	assign is_jump = (opc == OP_AJ) || (opc == OP_MJ) || (opc == OP_IJ) ||
		(opc == OP_OJ) || (opc == OP_ARJ);
	assign is_store = (opc == OP_RADD1) || (opc == OP_RSUB1) ||
		((opc >= OP_RLP) && (opc <= OP_STLP)) ||
		((opc >= OP_RSSET) && (opc <= OP_RSUBST));
	assign ret_jump = (opc == OP_ARJ) && take;
	assign p_wide = {{(W-AW){1'b0}}, p_r};

	lje_alu u_alu (
		.opc(opc),
		.a(a_r),
		.q(q_r),
		.x(x_r),
		.y(y_r),
		.a_nxt(a_nxt),
		.x_nxt(x_nxt),
		.probe(probe)
	);

	lje_cond u_cond (
		.opc(opc),
		.j(sel_j),
		.k(sel_k),
		.a(a_r),
		.q(q_r),
		.probe(probe),
		.keys(keys_s2_r),
		.hold(hold_s2_r),
		.take(take),
		.skip(skip),
		.stop(stop)
	);

	// Sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (wr_go && (avs_address == OFS_CMD)) begin
					state_nxt = S_EXEC;
				end
			end
			S_EXEC: begin
				if (is_store || ret_jump) begin
					state_nxt = S_STORE;
				end else begin
					state_nxt = S_IDLE;
				end
			end
			S_STORE: begin
				if (mem_wr_ack) begin
					state_nxt = S_IDLE;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= S_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Command register, accepted only while idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_r <= RST_CMD;
		end else if (idle && wr_go && (avs_address == OFS_CMD)) begin
			cmd_r <= avs_writedata[CMD_BITS-1:0];
		end
	end

	// Accumulator
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_r <= RST_WORD;
		end else if (exec && !is_jump) begin
			a_r <= a_nxt;
		end else if (idle && wr_go && (avs_address == OFS_ACC)) begin
			a_r <= wr_word[W-1:0];
		end
	end

	// Multiplier register, written by software only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_r <= RST_WORD;
		end else if (idle && wr_go && (avs_address == OFS_MQ)) begin
			q_r <= wr_word[W-1:0];
		end
	end

	// Operand word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			y_r <= RST_WORD;
		end else if (idle && wr_go && (avs_address == OFS_OPND)) begin
			y_r <= wr_word[W-1:0];
		end
	end

	// Store address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oaddr_r <= RST_ADDR;
		end else if (idle && wr_go && (avs_address == OFS_OADDR)) begin
			oaddr_r <= wr_word[AW-1:0];
		end
	end

	// Scratch register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			x_r <= RST_WORD;
		end else if (exec) begin
			if (ret_jump) begin
				x_r <= p_wide;
			end else if (!is_jump) begin
				x_r <= x_nxt;
			end
		end
	end

	// Instruction address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			p_r <= RST_ADDR;
		end else if (exec) begin
			if (is_jump && take) begin
				p_r <= y_r[AW-1:0];
			end else if (skip) begin
				p_r <= p_r + 15'h2;
			end else begin
				p_r <= p_r + 15'h1;
			end
		end else if ((state_r == S_STORE) && mem_wr_ack && rj_r) begin
			p_r <= p_r + 15'h1;
		end else if (idle && wr_go && (avs_address == OFS_PC)) begin
			p_r <= wr_word[AW-1:0];
		end
	end

	// Outcome flags of the last instruction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			skip_r <= 1'b0;
			jump_r <= 1'b0;
			rj_r <= 1'b0;
		end else if (exec) begin
			skip_r <= skip;
			jump_r <= is_jump && take;
			rj_r <= ret_jump;
		end
	end

	// Halt flag, set wins over clear
	assign clr_halt = wr_go && (avs_address == OFS_CTRL) &&
		avs_byteenable[0] && avs_writedata[CTRL_CLR_HALT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			halt_r <= 1'b0;
		end else if (exec && stop) begin
			halt_r <= 1'b1;
		end else if (clr_halt) begin
			halt_r <= 1'b0;
		end
	end

	// Core storage write request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_r <= 1'b0;
			waddr_r <= RST_ADDR;
			wdata_r <= RST_WORD;
			wmode_r <= K_NOJ0;
			wlow_r <= 1'b0;
		end else if (exec && ret_jump) begin
			req_r <= 1'b1;
			waddr_r <= y_r[AW-1:0];
			wdata_r <= p_wide;
			wmode_r <= sel_k;
			wlow_r <= 1'b1;
		end else if (exec && is_store) begin
			req_r <= 1'b1;
			waddr_r <= oaddr_r;
			wdata_r <= (opc == OP_STLP) ? x_nxt : a_nxt;
			wmode_r <= sel_k;
			wlow_r <= 1'b0;
		end else if (mem_wr_ack) begin
			req_r <= 1'b0;
		end
	end

	assign mem_wr_req = req_r;
	assign mem_wr_addr = waddr_r;
	assign mem_wr_data = wdata_r;
	assign mem_wr_mode = wmode_r;
	assign mem_wr_low_half = wlow_r;

	// Read data
	always_comb begin
		rd_mux = 32'h0;
		case (avs_address)
			OFS_ACC: rd_mux = {2'h0, a_r};
			OFS_MQ: rd_mux = {2'h0, q_r};
			OFS_SCR: rd_mux = {2'h0, x_r};
			OFS_PC: rd_mux = {17'h0, p_r};
			OFS_OPND: rd_mux = {2'h0, y_r};
			OFS_OADDR: rd_mux = {17'h0, oaddr_r};
			OFS_CMD: rd_mux = {20'h0, cmd_r};
			OFS_STAT: begin
				rd_mux[ST_BUSY] = busy;
				rd_mux[ST_HALT] = halt_r;
				rd_mux[ST_SKIP] = skip_r;
				rd_mux[ST_JUMP] = jump_r;
				rd_mux[ST_KEY_LSB +: NCH] = keys_s2_r;
				rd_mux[ST_HOLD_LSB +: NCH] = hold_s2_r;
			end
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readdata_r <= 32'h0;
		end else if (rd_cap) begin
			readdata_r <= rd_mux;
		end
	end
endmodule // lje_exec

// File: pkg/lje_pkg.sv
// Constants, opcodes and register map of the logical and jump execution block
package lje_pkg;
	localparam int W = 30;
	localparam int AW = 15;
	localparam int NCH = 8;
	localparam int BUS_AW = 6;

	typedef logic [5:0] lje_op_t;
	typedef logic [2:0] lje_sel_t;
	typedef logic [BUS_AW-1:0] lje_addr_t;

	// Opcodes (octal 36..64)
	localparam lje_op_t OP_RADD1 = 6'h1E;
	localparam lje_op_t OP_RSUB1 = 6'h1F;
	localparam lje_op_t OP_ELP = 6'h20;
	localparam lje_op_t OP_ALP = 6'h21;
	localparam lje_op_t OP_SLP = 6'h22;
	localparam lje_op_t OP_MCMP = 6'h23;
	localparam lje_op_t OP_RLP = 6'h24;
	localparam lje_op_t OP_RALP = 6'h25;
	localparam lje_op_t OP_RSLP = 6'h26;
	localparam lje_op_t OP_STLP = 6'h27;
	localparam lje_op_t OP_SSET = 6'h28;
	localparam lje_op_t OP_SCPL = 6'h29;
	localparam lje_op_t OP_SCLR = 6'h2A;
	localparam lje_op_t OP_SUBST = 6'h2B;
	localparam lje_op_t OP_RSSET = 6'h2C;
	localparam lje_op_t OP_RSCPL = 6'h2D;
	localparam lje_op_t OP_RSCLR = 6'h2E;
	localparam lje_op_t OP_RSUBST = 6'h2F;
	localparam lje_op_t OP_AJ = 6'h30;
	localparam lje_op_t OP_MJ = 6'h31;
	localparam lje_op_t OP_IJ = 6'h32;
	localparam lje_op_t OP_OJ = 6'h33;
	localparam lje_op_t OP_ARJ = 6'h34;

	// Store modes for which the branch selector is not interpreted, and the halting jump selector
	localparam lje_sel_t K_NOJ0 = 3'h0;
	localparam lje_sel_t K_NOJ4 = 3'h4;
	localparam lje_sel_t J_HALT = 3'h4;

	// Register byte offsets
	localparam lje_addr_t OFS_ACC = 6'h00;
	localparam lje_addr_t OFS_MQ = 6'h04;
	localparam lje_addr_t OFS_SCR = 6'h08;
	localparam lje_addr_t OFS_PC = 6'h0C;
	localparam lje_addr_t OFS_OPND = 6'h10;
	localparam lje_addr_t OFS_OADDR = 6'h14;
	localparam lje_addr_t OFS_CMD = 6'h18;
	localparam lje_addr_t OFS_STAT = 6'h1C;
	localparam lje_addr_t OFS_CTRL = 6'h20;

	// Command fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_J_LSB = 6;
	localparam int CMD_K_LSB = 9;
	localparam int CMD_BITS = 12;

	// Status fields
	localparam int ST_BUSY = 0;
	localparam int ST_HALT = 1;
	localparam int ST_SKIP = 2;
	localparam int ST_JUMP = 3;
	localparam int ST_KEY_LSB = 8;
	localparam int ST_HOLD_LSB = 16;
	localparam int CTRL_CLR_HALT = 0;

	// Reset values
	localparam logic [W-1:0] RST_WORD = 30'h0;
	localparam logic [AW-1:0] RST_ADDR = 15'h0;
	localparam logic [CMD_BITS-1:0] RST_CMD = 12'h0;
endpackage

// File: verif/lje_exec_chk.sv
// Port-level checker for the logical and jump execution unit
`timescale 1ns/100ps
module lje_exec_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire lje_pkg::lje_addr_t avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	// Store port and status
	input wire logic mem_wr_req,
	input wire logic [lje_pkg::AW-1:0] mem_wr_addr,
	input wire logic [lje_pkg::W-1:0] mem_wr_data,
	input wire logic mem_wr_low_half,
	input wire logic mem_wr_ack,
	input wire logic busy,
	input wire logic halted
);
	import lje_pkg::*;
	logic clr_w;
	assign clr_w = avs_write && !avs_waitrequest && avs_address == OFS_CTRL
		&& avs_writedata[CTRL_CLR_HALT];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_cmd;
		avs_write && !avs_waitrequest && avs_address == OFS_CMD && !busy;
	endsequence
	sequence s_ack;
		mem_wr_req && mem_wr_ack;
	endsequence
	chk_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not low one cycle after request");
	chk_cmd_busy: assert property (s_cmd |=> busy ##1 (mem_wr_req || !busy))
		else $error("command did not run one execute cycle");
	chk_req_hold: assert property (mem_wr_req && !mem_wr_ack |=> mem_wr_req &&
		$stable(mem_wr_data) && $stable(mem_wr_addr) && $stable(mem_wr_low_half))
		else $error("store request changed before acknowledge");
	chk_ack_release: assert property (s_ack |=> !mem_wr_req && !busy)
		else $error("store or busy not released after acknowledge");
	chk_req_busy: assert property (mem_wr_req |-> busy)
		else $error("store request while idle");
	chk_rj_upper: assert property (mem_wr_req && mem_wr_low_half |->
		mem_wr_data[W-1:AW] == '0)
		else $error("return address store upper half not zero");
	chk_halt_src: assert property ($rose(halted) |-> $past(busy))
		else $error("halt set outside an instruction");
	chk_halt_keep: assert property (halted && !clr_w |=> halted)
		else $error("halt flag lost without clear");
endmodule // lje_exec_chk

bind lje_exec lje_exec_chk u_chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_waitrequest, .mem_wr_req, .mem_wr_addr, .mem_wr_data,
	.mem_wr_low_half, .mem_wr_ack, .busy, .halted);

// File: verif/lje_mem_model.sv
// Core storage model answering store requests after a set lag
`timescale 1ns/100ps
module lje_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Store port
	input wire logic req,
	input wire logic [14:0] addr,
	input wire logic [29:0] data,
	input wire logic low,
	input wire logic [2:0] lag,
	output logic ack
);
	logic [2:0] cnt_r;
	logic [29:0] mem_r [0:15];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 3'h0;
			ack <= 1'b0;
		end else if (ack || !req) begin
			cnt_r <= 3'h0;
			ack <= 1'b0;
		end else if (cnt_r >= lag) begin
			ack <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (req && !ack && cnt_r >= lag) begin
			mem_r[addr[3:0]] <= low ? {mem_r[addr[3:0]][29:15], data[14:0]} : data;
		end
	end
endmodule // lje_mem_model

// File: verif/tb_logical_ops_and_jump_execution.sv
// Self-checking bench for the logical and jump execution unit
`timescale 1ns/100ps
module tb_logical_ops_and_jump_execution;
	import lje_pkg::*;
`define CHK(n, e, s) n_compared++; if ((s) !== (e)) begin fail_count++; \
	$display("wrong value %s expected %h seen %h", n, e, s); end
	logic clk, rst, avs_read, avs_write, rd_on, avs_waitrequest;
	logic mem_wr_req, mem_wr_low_half, mem_wr_ack, busy, halted;
	lje_addr_t avs_address;
	logic [31:0] avs_writedata, avs_readdata, er;
	logic [3:0] avs_byteenable;
	logic [NCH-1:0] console_keys, chan_hold;
	logic [AW-1:0] mem_wr_addr, pc, oa;
	logic [W-1:0] mem_wr_data, a, q, y;
	lje_sel_t mem_wr_mode;
	logic [2:0] lag;
	logic [48:0] ev;
	logic [31:0] rq[$];
	logic [48:0] mq[$];
	int fail_count, n_compared, cyc;

	lje_exec u_lje_exec (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .console_keys, .chan_hold,
		.mem_wr_req, .mem_wr_addr, .mem_wr_data, .mem_wr_mode, .mem_wr_low_half,
		.mem_wr_ack, .busy, .halted);
	lje_mem_model u_lje_mem_model (.clk, .rst, .req(mem_wr_req), .addr(mem_wr_addr),
		.data(mem_wr_data), .low(mem_wr_low_half), .lag, .ack(mem_wr_ack));

	initial clk = 1'b0;
	always #20 clk = ~clk;

	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			report_and_stop;
		end
	end

	// Results taken off the queues as they appear
	always @(negedge clk) begin
		if (avs_read && !avs_waitrequest && rd_on) begin
			er = rq.size() ? rq.pop_front() : 'x;
			`CHK("readdata", er, avs_readdata)
		end
		if (mem_wr_req && mem_wr_ack) begin
			ev = mq.size() ? mq.pop_front() : 'x;
			`CHK("store", ev, {mem_wr_addr, mem_wr_data, mem_wr_low_half, mem_wr_mode})
		end
	end

	task wt;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
	endtask

	task bw(input lje_addr_t ad, input logic [31:0] d);
		avs_address <= ad;
		avs_writedata <= d;
		avs_write <= 1'b1;
		wt();
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task rd(input lje_addr_t ad, input logic [31:0] e);
		rq.push_back(e);
		avs_address <= ad;
		avs_read <= 1'b1;
		rd_on <= 1'b1;
		wt();
		avs_read <= 1'b0;
		rd_on <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic cnd(input lje_sel_t j, input logic [W-1:0] v);
		case (j)
			3'h0: return 1'b0;
			3'h1: return 1'b1;
			3'h2: return !q[W-1];
			3'h3: return q[W-1];
			3'h4: return v == '0;
			3'h5: return v != '0;
			3'h6: return !v[W-1];
			default: return v[W-1];
		endcase
	endfunction

	task run(input lje_op_t op, input lje_sel_t j, input lje_sel_t k);
		logic [W-1:0] x, na;
		logic [AW-1:0] np;
		logic st, tk, rj, hl, sk;
		console_keys <= 8'($urandom);
		chan_hold <= 8'($urandom);
		lag <= 3'($urandom);
		bw(OFS_ACC, 32'(a));
		bw(OFS_MQ, 32'(q));
		bw(OFS_OPND, 32'(y));
		bw(OFS_OADDR, 32'(oa));
		bw(OFS_PC, 32'(pc));
		x = y & q;
		na = a;
		st = op[2] && op inside {[OP_RADD1:OP_RSUBST]};
		{tk, rj, hl, sk} = 4'h0;
		np = pc + 15'h1;
		case (op)
			OP_RADD1: na = y + 30'h1;
			OP_RSUB1: na = y - 30'h1;
			OP_ELP, OP_RLP: na = x;
			OP_ALP, OP_RALP: na = a + x;
			OP_SLP, OP_RSLP: na = a - x;
			OP_MCMP: sk = cnd(j, a - x);
			OP_STLP: begin
				x = a & q;
				sk = k != K_NOJ0 && k != K_NOJ4 && cnd(j, a);
			end
			OP_SSET, OP_RSSET: na = a | y;
			OP_SCPL, OP_RSCPL: na = a ^ y;
			OP_SCLR, OP_RSCLR: na = a & ~y;
			OP_SUBST, OP_RSUBST: na = (a & ~q) | x;
			OP_AJ: tk = cnd(j, a);
			OP_MJ: begin
				tk = j == 3'h0 || j[2] || console_keys[j];
				hl = j == J_HALT || j[2] && console_keys[j];
			end
			OP_IJ: tk = chan_hold[j];
			OP_OJ: tk = !chan_hold[j];
			OP_ARJ: rj = cnd(j, a);
			default: ;
		endcase
		if (sk) np = pc + 15'h2;
		if (tk) np = y[AW-1:0];
		if (rj) begin
			x = {15'h0, pc};
			np = y[AW-1:0] + 15'h1;
			mq.push_back({y[AW-1:0], x, 1'b1, k});
		end
		if (st) mq.push_back({oa, op == OP_STLP ? x : na, 1'b0, k});
		bw(OFS_CMD, {20'h0, k, j, op});
		if (st && lag > 3'h4) bw(OFS_ACC, 32'(~na));
		do @(negedge clk); while (busy !== 1'b0);
		`CHK("halted", hl, halted)
		if (rj) begin
			`CHK("saved address", pc, u_lje_mem_model.mem_r[y[3:0]][14:0])
		end
		@(posedge clk);
		rd(OFS_ACC, 32'(na));
		rd(OFS_PC, 32'(np));
		rd(OFS_STAT, {8'h0, chan_hold, console_keys, 4'h0, tk || rj, sk, hl, 1'b0});
		if (rj || op inside {[OP_ELP:OP_STLP], OP_SUBST, OP_RSUBST}) rd(OFS_SCR, 32'(x));
		if (hl) bw(OFS_CTRL, 32'h1);
	endtask

	initial begin
		{avs_read, avs_write, rd_on} = 3'h0;
		avs_address = '0;
		avs_writedata = '0;
		avs_byteenable = 4'hF;
		{console_keys, chan_hold, lag} = '0;
		{cyc, fail_count, n_compared} = '0;
		rst = 1'b1;
		void'($urandom(2));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_ACC, 32'h0);
		rd(OFS_PC, 32'h0);
		bw(OFS_SCR, 32'hFFFFFFFF);
		rd(OFS_SCR, 32'h0);
		rd(6'h3C, 32'h0);
		for (int i = 0; i < 3; i++) begin
			for (int o = OP_RADD1 - 1; o <= OP_ARJ; o++) begin
				for (int j = 0; j < 8; j++) begin
					a = i == 0 ? '0 : 30'($urandom);
					q = 30'($urandom);
					y = i == 0 ? '1 : 30'($urandom);
					pc = i == 0 ? 15'h7FFF : 15'($urandom);
					oa = 15'($urandom);
					run(6'(o), 3'(j), 3'($urandom));
				end
			end
		end
		`CHK("pending stores", 0, mq.size())
		report_and_stop;
	end
endmodule // tb_logical_ops_and_jump_execution
